// file: logic/pfm_pkg.sv
// constants and types shared by the port function multiplexer
package pfm_pkg;
   localparam int unsigned PFM_PORT_W    = 8;
   localparam int unsigned PFM_PORTD_W   = 6;
   localparam int unsigned PFM_XA_W      = 6;
   localparam int unsigned PFM_LINES_FULL = 62;
   localparam int unsigned PFM_LINES_RED  = 51;
   // bit positions inside port a
   localparam int unsigned PFM_PA_CMP_FIVE   = 3;
   localparam int unsigned PFM_PA_CMP_ONE_LO = 3;
   // bit positions inside port g and h
   localparam int unsigned PFM_PG_RW     = 7;
   localparam int unsigned PFM_PG_GP     = 6;
   localparam int unsigned PFM_PH_IO_CS   = 4;
   localparam int unsigned PFM_PH_PROG_CS = 7;
   // pins present on the reduced-pin variant
   localparam logic [7:0] PFM_PG_RED_MASK = 8'h80;
   localparam logic [7:0] PFM_PH_RED_MASK = 8'h0f;
   localparam logic [7:0] PFM_ALL_MASK    = 8'hff;
   localparam logic [7:0] PFM_RST_BYTE    = 8'h00;
   localparam logic [1:0] PFM_RST_MODE    = 2'h0;
   // operating modes as latched from the mode pins
   typedef enum logic [3:0] {
      PFM_SINGLE = 4'h1,
      PFM_EXPAND = 4'h2,
      PFM_BOOT   = 4'h4,
      PFM_TEST   = 4'h8
   } pfm_mode_e;
   localparam logic [1:0] PFM_MODE_SINGLE = 2'h1;
   localparam logic [1:0] PFM_MODE_EXPAND = 2'h3;
   localparam logic [1:0] PFM_MODE_BOOT   = 2'h0;
   localparam logic [1:0] PFM_MODE_TEST   = 2'h2;
endpackage : pfm_pkg

// file: logic/pfm_pin_cell.sv
// one multiplexed port pin cell, registered output
module pfm_pin_cell
   import pfm_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic present_i,
   input  wire logic sel_i,
   input  wire logic fn_out_i,
   input  wire logic fn_oe_i,
   input  wire logic gp_out_i,
   input  wire logic gp_oe_i,
   output logic      pin_o,
   output logic      pin_oe_o
);
   logic out_d, out_q, oe_d, oe_q;

   // the special function overrides gpio data and direction
   always_comb
   begin
      out_d = sel_i ? fn_out_i : gp_out_i;
      oe_d  = present_i & (sel_i ? fn_oe_i : gp_oe_i);
      if (!present_i)
      begin
         out_d = 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         out_q <= 1'b0;
         oe_q  <= 1'b0;
      end
      else
      begin
         out_q <= out_d;
         oe_q  <= oe_d;
      end
   end

   assign pin_o    = out_q;
   assign pin_oe_o = oe_q;
endmodule : pfm_pin_cell

// file: logic/pfm_port_mux.sv
// top of the port function multiplexer for ports a to h
module pfm_port_mux
   import pfm_pkg::*;
#(
   parameter bit REDUCED = 1'b0
)(
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic [1:0]           mode_pins_i,
   // gpio register side, per port a,b,c,d,f,g,h
   input  wire logic [7:0][7:0]      gp_out_i,
   input  wire logic [7:0][7:0]      gp_oe_i,
   // function enables from control registers
   input  wire logic [7:0]           tmr_en_i,
   input  wire logic [7:0]           tmr_out_i,
   input  wire logic [7:0]           tmr_oe_i,
   input  wire logic [5:0]           ser_en_i,
   input  wire logic [5:0]           ser_out_i,
   input  wire logic [5:0]           ser_oe_i,
   input  wire logic [5:0]           xa_en_i,
   input  wire logic [5:0]           xa_i,
   input  wire logic [7:0]           ph_en_i,
   input  wire logic [7:0]           ph_fn_i,
   input  wire logic [15:0]          addr_i,
   input  wire logic [7:0]           data_out_i,
   input  wire logic                 data_oe_i,
   input  wire logic                 rd_wr_i,
   // pins
   input  wire logic [7:0][7:0]      pin_i,
   output logic      [7:0][7:0]      pin_o,
   output logic      [7:0][7:0]      pin_oe_o,
   output logic      [7:0]           analog_input_channels_o,
   output logic      [7:0]           data_in_o,
   output logic      [7:0]           pa_in_o,
   output logic      [5:0]           pd_in_o,
   output logic                      expanded_o
);
   // port index: 0 a, 1 b, 2 c, 3 d, 4 e, 5 f, 6 g, 7 h
   localparam int unsigned PA = 0, PB = 1, PC = 2, PD = 3;
   localparam int unsigned PE = 4, PF = 5, PG = 6, PH = 7;

   pfm_mode_e   mode_d, mode_q;
   logic        latched_q, latched_d;
   logic [7:0]  adc_d, adc_q, din_d, din_q, pa_d, pa_q;
   logic [5:0]  pd_d, pd_q;
   logic [7:0][7:0] sel, fn_out, fn_oe, present;
   logic        exp_mode, exp_d, exp_q;

   function automatic pfm_mode_e decode_mode(input logic [1:0] m);
      case (m)
         PFM_MODE_SINGLE: decode_mode = PFM_SINGLE;
         PFM_MODE_EXPAND: decode_mode = PFM_EXPAND;
         PFM_MODE_BOOT:   decode_mode = PFM_BOOT;
         PFM_MODE_TEST:   decode_mode = PFM_TEST;
         default:         decode_mode = PFM_SINGLE;
      endcase
   endfunction : decode_mode

   // mode caught on the first clock after reset release, not in reset
   always_comb
   begin
      latched_d = 1'b1;
      mode_d    = latched_q ? mode_q : decode_mode(mode_pins_i);
      // bus modes held in a flop so expanded_o leaves a register
      exp_d     = (mode_d == PFM_EXPAND) || (mode_d == PFM_TEST);
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         latched_q <= 1'b0;
         mode_q    <= PFM_SINGLE;
         exp_q     <= 1'b0;
      end
      else
      begin
         latched_q <= latched_d;
         mode_q    <= mode_d;
         exp_q     <= exp_d;
      end
   end

   // expanded or special test; until latched, stay gpio
   assign exp_mode = exp_q;

   // selection and function values for every pin
   always_comb
   begin
      sel     = '0;
      fn_out  = '0;
      fn_oe   = '0;
      present = '0;
      for (int p = 0; p < PFM_PORT_W; p++)
      begin
         present[p] = PFM_ALL_MASK;
      end
      present[PD] = 8'h3f;
      present[PE] = 8'h00;
      if (REDUCED)
      begin
         present[PG] = PFM_PG_RED_MASK;
         present[PH] = PFM_PH_RED_MASK;
      end
      // timer functions; control enables come in low out of reset
      sel[PA]    = tmr_en_i;
      fn_out[PA] = tmr_out_i;
      fn_oe[PA]  = tmr_oe_i & 8'hf8;
      // serial pins; direction set by the serial blocks
      sel[PD]    = {2'b00, ser_en_i};
      fn_out[PD] = {2'b00, ser_out_i};
      fn_oe[PD]  = {2'b00, ser_oe_i};
      // address and data buses in expanded modes
      sel[PB]    = {8{exp_mode}};
      fn_out[PB] = addr_i[15:8];
      fn_oe[PB]  = PFM_ALL_MASK;
      sel[PF]    = {8{exp_mode}};
      fn_out[PF] = addr_i[7:0];
      fn_oe[PF]  = PFM_ALL_MASK;
      sel[PC]    = {8{exp_mode}};
      fn_out[PC] = data_out_i;
      fn_oe[PC]  = {8{data_oe_i}};
      // g7 read/write, g5-g0 extended address gated by mode
      sel[PG]    = {exp_mode, 1'b0, xa_en_i & {PFM_XA_W{exp_mode}}};
      fn_out[PG] = {rd_wr_i, 1'b0, xa_i};
      fn_oe[PG]  = 8'hbf;
      // pwm on h3-h0, chip selects on h7-h4, always outputs
      sel[PH]    = ph_en_i;
      fn_out[PH] = ph_fn_i;
      fn_oe[PH]  = PFM_ALL_MASK;
   end

   // one cell per pin; port e cells never drive
   for (genvar p = 0; p < 8; p++)
   begin : g_port
      for (genvar b = 0; b < 8; b++)
      begin : g_bit
         pfm_pin_cell u_cell (
            .clk_i    (clk_i),
            .rst_i    (rst_i),
            .present_i(present[p][b]),
            .sel_i    (sel[p][b]),
            .fn_out_i (fn_out[p][b]),
            .fn_oe_i  (fn_oe[p][b]),
            .gp_out_i (gp_out_i[p][b]),
            .gp_oe_i  (gp_oe_i[p][b]),
            .pin_o    (pin_o[p][b]),
            .pin_oe_o (pin_oe_o[p][b])
         );
      end
   end

   // registered input paths to the peripherals
   always_comb
   begin
      adc_d = pin_i[PE];
      din_d = pin_i[PC];
      pa_d  = pin_i[PA];
      pd_d  = pin_i[PD][5:0];
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         adc_q <= PFM_RST_BYTE;
         din_q <= PFM_RST_BYTE;
         pa_q  <= PFM_RST_BYTE;
         pd_q  <= '0;
      end
      else
      begin
         adc_q <= adc_d;
         din_q <= din_d;
         pa_q  <= pa_d;
         pd_q  <= pd_d;
      end
   end

   assign analog_input_channels_o = adc_q;
   assign data_in_o               = din_q;
   assign pa_in_o                 = pa_q;
   assign pd_in_o                 = pd_q;
   assign expanded_o              = exp_mode;

   // checks
   property p_port_e_input;
      @(posedge clk_i) disable iff (rst_i) pin_oe_o[PE] == 8'h00;
   endproperty
   a_port_e_input: assert property (p_port_e_input) else $error("port e drove");

   property p_port_d_top;
      @(posedge clk_i) disable iff (rst_i) pin_oe_o[PD][7:6] == 2'b00;
   endproperty
   a_port_d_top: assert property (p_port_d_top) else $error("port d bit 7:6 drove");

   property p_reduced;
      @(posedge clk_i) disable iff (rst_i)
         REDUCED |-> ((pin_oe_o[PG] & ~PFM_PG_RED_MASK) == 8'h00
                      && (pin_oe_o[PH] & ~PFM_PH_RED_MASK) == 8'h00);
   endproperty
   a_reduced: assert property (p_reduced) else $error("absent pin drove");

   property p_addr_high;
      @(posedge clk_i) disable iff (rst_i)
         exp_mode |=> (pin_o[PB] == $past(addr_i[15:8]) && pin_oe_o[PB] == 8'hff);
   endproperty
   a_addr_high: assert property (p_addr_high) else $error("port b address wrong");

   property p_addr_low;
      @(posedge clk_i) disable iff (rst_i)
         exp_mode |=> pin_o[PF] == $past(addr_i[7:0]);
   endproperty
   a_addr_low: assert property (p_addr_low) else $error("port f address wrong");

   property p_gpio_b;
      @(posedge clk_i) disable iff (rst_i)
         (latched_q && !exp_mode) |=> pin_o[PB] == $past(gp_out_i[PB]);
   endproperty
   a_gpio_b: assert property (p_gpio_b) else $error("port b not gpio");

   property p_xa_gate;
      @(posedge clk_i) disable iff (rst_i)
         !exp_mode |=> pin_o[PG][5:0] == ($past(gp_out_i[PG][5:0]) & $past(present[PG][5:0]));
   endproperty
   a_xa_gate: assert property (p_xa_gate) else $error("extended address out of mode");

   property p_g6_gpio;
      @(posedge clk_i) disable iff (rst_i)
         1'b1 |=> pin_o[PG][PFM_PG_GP] ==
                  ($past(gp_out_i[PG][PFM_PG_GP]) & $past(present[PG][PFM_PG_GP]));
   endproperty
   a_g6_gpio: assert property (p_g6_gpio) else $error("g6 not gpio");

   property p_ph_fn;
      @(posedge clk_i) disable iff (rst_i)
         (ph_en_i[0] && present[PH][0]) |=> (pin_o[PH][0] == $past(ph_fn_i[0]) && pin_oe_o[PH][0]);
   endproperty
   a_ph_fn: assert property (p_ph_fn) else $error("pwm one not on h0");

   property p_adc;
      @(posedge clk_i) disable iff (rst_i) 1'b1 |=> analog_input_channels_o == $past(pin_i[PE]);
   endproperty
   a_adc: assert property (p_adc) else $error("analog channels wrong");

   property p_ser;
      @(posedge clk_i) disable iff (rst_i)
         ser_en_i[1] |=> (pin_o[PD][1] == $past(ser_out_i[1]));
   endproperty
   a_ser: assert property (p_ser) else $error("transmit not on d1");

   c_expanded: cover property (@(posedge clk_i) disable iff (rst_i) exp_mode);
   c_single:   cover property (@(posedge clk_i) disable iff (rst_i) latched_q && !exp_mode);
   c_xa:       cover property (@(posedge clk_i) disable iff (rst_i) exp_mode && xa_en_i[5]);
   c_timer:    cover property (@(posedge clk_i) disable iff (rst_i) tmr_en_i[7]);
endmodule : pfm_port_mux

// file: bench/pfm_ext_model.sv
// far-side model: board devices and memory seen on the port pins
module pfm_ext_model
   import pfm_pkg::*;
(
   input  wire logic [7:0][7:0] pin_o,
   input  wire logic [7:0][7:0] pin_oe_o,
   input  wire logic [7:0][7:0] ext_i,
   output logic      [7:0][7:0] pin_i
);
   timeunit 1ns;
   timeprecision 1ps;
   // released bits show the board pattern, never the last level driven
   assign pin_i = (pin_o & pin_oe_o) | (ext_i & ~pin_oe_o);
endmodule : pfm_ext_model

// file: bench/pfm_port_mux_tb_top.sv
// self-checking bench for the port function multiplexer
module pfm_port_mux_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import pfm_pkg::*;
   logic                clk_i, rst_i, data_oe_i, rd_wr_i, expanded_o;
   logic [1:0]          mode_pins_i;
   logic [7:0][7:0]     gp_out_i, gp_oe_i, pin_i, pin_o, pin_oe_o, ext, red_pin_o, red_pin_oe;
   logic [7:0]          tmr_en_i, tmr_out_i, tmr_oe_i, ph_en_i, ph_fn_i, data_out_i;
   logic [7:0]          analog_input_channels_o, data_in_o, pa_in_o;
   logic [5:0]          ser_en_i, ser_out_i, ser_oe_i, xa_en_i, xa_i, pd_in_o;
   logic [15:0]         addr_i;
   int                  num_errors = 0;
   int                  n_compared = 0;

   pfm_port_mux #(.REDUCED(1'b0)) dut_u (.clk_i, .rst_i, .mode_pins_i, .gp_out_i, .gp_oe_i,
      .tmr_en_i, .tmr_out_i, .tmr_oe_i, .ser_en_i, .ser_out_i, .ser_oe_i, .xa_en_i, .xa_i,
      .ph_en_i, .ph_fn_i, .addr_i, .data_out_i, .data_oe_i, .rd_wr_i, .pin_i, .pin_o,
      .pin_oe_o, .analog_input_channels_o, .data_in_o, .pa_in_o, .pd_in_o, .expanded_o);
   pfm_ext_model ext_u (.pin_o, .pin_oe_o, .ext_i(ext), .pin_i);
   // reduced-pin variant on the same stimulus; its absent pins must stay silent
   pfm_port_mux #(.REDUCED(1'b1)) red_u (.clk_i, .rst_i, .mode_pins_i, .gp_out_i, .gp_oe_i,
      .tmr_en_i, .tmr_out_i, .tmr_oe_i, .ser_en_i, .ser_out_i, .ser_oe_i, .xa_en_i, .xa_i,
      .ph_en_i, .ph_fn_i, .addr_i, .data_out_i, .data_oe_i, .rd_wr_i, .pin_i,
      .pin_o(red_pin_o), .pin_oe_o(red_pin_oe), .analog_input_channels_o(), .data_in_o(),
      .pa_in_o(), .pd_in_o(), .expanded_o());

   // free-running 50 mhz clock
   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   task finish_test;
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test

   task chk(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
         num_errors++;
      end
   endtask : chk

   // one registered stage, sampled away from the edge
   task step;
      @(posedge clk_i);
      @(negedge clk_i);
   endtask : step

   // function enables off, pins released except ports b, f and g7 in bus modes
   task quiet;
      {tmr_en_i, tmr_out_i, tmr_oe_i, ph_en_i, ph_fn_i, data_out_i} = '0;
      {ser_en_i, ser_out_i, ser_oe_i, xa_en_i, xa_i, addr_i, data_oe_i, rd_wr_i} = '0;
      gp_out_i = '0;
      gp_oe_i = '0;
   endtask : quiet

   // straps are only taken on the first clock after reset, so every mode needs its own reset
   task do_reset(input logic [1:0] m);
      quiet();
      rst_i = 1'b1;
      mode_pins_i = m;
      repeat (12) @(negedge clk_i);
      chk(pin_oe_o, 64'h0);
      chk(pin_o, 64'h0);
      rst_i = 1'b0;
      repeat (3) @(negedge clk_i);
   endtask : do_reset

   // gpio modes: bus ports stay gpio, absent pins never drive
   task t_single(input logic [1:0] m);
      do_reset(m);
      {xa_en_i, xa_i, addr_i, data_oe_i} = {6'h3f, 6'h2d, 16'hc3a5, 1'b1};
      gp_oe_i = {8{8'hff}};
      gp_out_i = 64'ha55a3cc30ff09669;
      step();
      chk(expanded_o, 1'b0);
      chk(pin_oe_o, 64'hffffff003fffffff);
      chk(pin_o, 64'ha55a3c000ff09669);
      chk(red_pin_oe, 64'h0f80ff003fffffff);
      chk(red_pin_o, 64'h05003c000ff09669);
      gp_oe_i = '0;
      repeat (2) step();
      chk(pin_oe_o, 64'h0);
      chk(analog_input_channels_o, ext[4]);
      chk(pa_in_o, ext[0]);
      chk(pd_in_o, ext[3][5:0]);
      chk(data_in_o, ext[2]);
   endtask : t_single

   // bus modes: address, data and read/write on their ports
   task t_expand(input logic [1:0] m);
      do_reset(m);
      gp_oe_i = {8{8'hff}};
      gp_out_i = 64'ha55a3cc30ff09669;
      {addr_i, data_out_i, data_oe_i, rd_wr_i} = {16'hc3a5, 8'h96, 1'b1, 1'b0};
      {xa_en_i, xa_i} = {6'h3f, 6'h2d};
      step();
      chk(expanded_o, 1'b1);
      chk(pin_o[1], 8'hc3);
      chk(pin_o[5], 8'ha5);
      chk(pin_o[2], 8'h96);
      chk(pin_o[6], 8'h6d);
      chk(pin_oe_o[6], 8'hff);
      chk(red_pin_oe[6], 8'h80);
      {data_oe_i, rd_wr_i} = 2'b01;
      repeat (2) step();
      chk(pin_oe_o[2], 8'h00);
      chk(data_in_o, ext[2]);
      chk(pin_o[6][7], 1'b1);
   endtask : t_expand

   // peripheral functions take pins with gpio directions left as inputs
   task t_funcs;
      do_reset(PFM_MODE_SINGLE);
      {tmr_en_i, tmr_out_i, tmr_oe_i} = {8'hff, 8'ha6, 8'hff};
      {ser_en_i, ser_out_i, ser_oe_i} = {6'h3f, 6'h2a, 6'h0a};
      {ph_en_i, ph_fn_i} = {8'hff, 8'h93};
      repeat (2) step();
      chk(pin_oe_o[0], 8'hf8);
      chk(pin_o[0][7:3], 5'h14);
      chk(pa_in_o[2:0], ext[0][2:0]);
      chk(pin_oe_o[3], 8'h0a);
      chk(pin_o[3] & 8'h0a, 8'h0a);
      chk(pd_in_o[0], ext[3][0]);
      chk(pin_o[7], 8'h93);
      chk(pin_oe_o[7], 8'hff);
      chk(red_pin_o[7], 8'h03);
   endtask : t_funcs

   // main sequence, every strap setting at least once
   initial
   begin
      rst_i = 1'b1;
      mode_pins_i = PFM_MODE_SINGLE;
      ext = 64'h1e2d3c4b5a697887;
      quiet();
      t_single(PFM_MODE_SINGLE);
      t_single(PFM_MODE_BOOT);
      t_expand(PFM_MODE_EXPAND);
      t_expand(PFM_MODE_TEST);
      t_funcs();
      finish_test();
   end

   // watchdog: the run needs under two microseconds
   initial
   begin
      #50000;
      num_errors++;
      finish_test();
   end
endmodule : pfm_port_mux_tb_top
